// ---- dbdac_pkg.sv ----
package dbdac_pkg;
   // Register byte offsets of the controller's own registers
   localparam logic [3:0] REG_CODE = 4'h0;
   localparam logic [3:0] REG_CTRL = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   // Control register fields
   localparam int CTRL_GO = 0;
   localparam int CTRL_LOAD = 1;
   localparam int CTRL_SEG_LO = 4;
   localparam int CTRL_WIDTH_LO = 8;
   // Data path width codes
   localparam logic [1:0] WIDTH_4 = 2'h0;
   localparam logic [1:0] WIDTH_8 = 2'h1;
   localparam logic [1:0] WIDTH_16 = 2'h2;
   // Status register fields
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;
   // Reset values
   localparam logic [11:0] CODE_RESET = 12'h000;
   localparam logic [2:0] SEG_RESET = 3'h7;
   // Timing: setup and strobe width, in ns, and derived cycle counts
   localparam int CLK_PERIOD_PS = 5000;
   localparam int SETUP_NS = 250;
   localparam int STROBE_NS = 250;
   localparam int SETUP_CYC = (SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int STROBE_CYC = (STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TIMER_W = 8;
   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SETUP = 3'b001,
      ST_STROBE = 3'b010,
      ST_HOLD = 3'b011,
      ST_LSETUP = 3'b100,
      ST_LSTROBE = 3'b101,
      ST_DONE = 3'b110
   } dbdac_state_t;
endpackage

// ---- dbdac_timer.sv ----
`timescale 1ns/1ps
// Down counter that flags expiry of a loaded interval
module dbdac_timer (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic load, // Load a new interval
   input wire logic [dbdac_pkg::TIMER_W-1:0] count, // Interval in cycles
   output logic expired // Interval has run out
);
   logic [dbdac_pkg::TIMER_W-1:0] remain;

   // Count down to zero, reporting expiry from one onward
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         remain <= '0;
      end else if (load) begin
         remain <= count;
      end else if (remain != '0) begin
         remain <= remain - 1'b1;
      end
   end

   assign expired = (remain <= {{(dbdac_pkg::TIMER_W-1){1'b0}}, 1'b1}) && !load;
endmodule

// ---- dbdac_host.sv ----
`timescale 1ns/1ps
// Operation
// - Strobe 1 passes, 0 holds; data stable across strobe fall.
// - Chip select and segment enable active together at least 250 ns.
// - Every strobe held active at least 250 ns per write.
// - Twelve bits written over 4-, 8- or 16-bit paths, then transfer.
module dbdac_host (
   input wire logic aclk, // Clock, 200 MHz
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic [3:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [3:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   output logic [11:0] dac_data, // Data pins, [11] is bit 1 (MSB)
   output logic chip_select_n, // Chip select, active low
   output logic low_nibble_enable, // Bits 12..9 enable
   output logic middle_nibble_enable, // Bits 8..5 enable
   output logic high_nibble_enable, // Bits 4..1 enable
   output logic transfer_load_strobe // Input to converter register transfer
);
   dbdac_pkg::dbdac_state_t state;
   logic [11:0] code;
   logic [2:0] seg_mask;
   logic [1:0] width;
   logic auto_load;
   logic done;
   logic [2:0] pending;
   logic [2:0] group;
   logic aw_got, w_got;
   logic [3:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic t_load;
   logic [dbdac_pkg::TIMER_W-1:0] t_count;
   logic t_exp;
   logic wr_fire, go_req;

   // Segments covered by one write for a given path width
   function automatic logic [2:0] width_group(input logic [1:0] w, input logic [2:0] p);
      logic [2:0] g;
      g = 3'h0;
      case (w)
         dbdac_pkg::WIDTH_4: g = p & (~p + 3'h1); // Lowest pending only
         dbdac_pkg::WIDTH_8: g = (p[0] || p[1]) ? (p & 3'h3) : (p & 3'h4);
         default: g = p; // 16-bit path covers all three
      endcase
      return g;
   endfunction

   // Byte address decode of the register map
   function automatic logic addr_ok(input logic [3:0] a);
      return (a == dbdac_pkg::REG_CODE) || (a == dbdac_pkg::REG_CTRL)
         || (a == dbdac_pkg::REG_STATUS);
   endfunction

   assign wr_fire = aw_got && w_got && !s_axi_bvalid;
   assign go_req = wr_fire && (aw_addr == dbdac_pkg::REG_CTRL) && w_data[dbdac_pkg::CTRL_GO]
      && (state == dbdac_pkg::ST_IDLE);

   dbdac_timer dbdac_timer_inst (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(t_load),
      .count(t_count),
      .expired(t_exp)
   );

   // Write address and data capture, taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_got <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb; // Strobes belong to the data beat
         end else if (wr_fire) begin
            w_got <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_got && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !w_got && !(s_axi_wvalid && s_axi_wready);
      end
   end

   // Write response; code and config writes are answered but dropped while a sequence runs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= addr_ok(aw_addr) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Software registers: code, segment mask, path width, auto load
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         code <= dbdac_pkg::CODE_RESET;
         seg_mask <= dbdac_pkg::SEG_RESET;
         width <= dbdac_pkg::WIDTH_16;
         auto_load <= 1'b1;
      end else if (wr_fire && state == dbdac_pkg::ST_IDLE) begin
         if (aw_addr == dbdac_pkg::REG_CODE && w_strb[0])
            code[7:0] <= w_data[7:0];
         if (aw_addr == dbdac_pkg::REG_CODE && w_strb[1])
            code[11:8] <= w_data[11:8];
         if (aw_addr == dbdac_pkg::REG_CTRL && w_strb[0]) begin
            auto_load <= w_data[dbdac_pkg::CTRL_LOAD];
            seg_mask <= w_data[dbdac_pkg::CTRL_SEG_LO +: 3];
         end
         if (aw_addr == dbdac_pkg::REG_CTRL && w_strb[1])
            width <= w_data[dbdac_pkg::CTRL_WIDTH_LO +: 2];
      end
   end

   // Read channel with one-cycle answer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= addr_ok(s_axi_araddr) ? 2'h0 : 2'h2;
         case (s_axi_araddr)
            dbdac_pkg::REG_CODE: s_axi_rdata <= {20'h00000, code};
            dbdac_pkg::REG_CTRL: s_axi_rdata <= {22'h000000, width, 1'b0, seg_mask,
               2'h0, auto_load, 1'b0};
            dbdac_pkg::REG_STATUS: s_axi_rdata <= {30'h00000000, done,
               state != dbdac_pkg::ST_IDLE};
            default: s_axi_rdata <= 32'h0000_0000;
         endcase
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

   // Pin sequencer: setup, strobe, hold per group, then transfer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= dbdac_pkg::ST_IDLE;
         pending <= 3'h0;
         group <= 3'h0;
         done <= 1'b0;
         dac_data <= 12'h000;
         chip_select_n <= 1'b1;
         low_nibble_enable <= 1'b0;
         middle_nibble_enable <= 1'b0;
         high_nibble_enable <= 1'b0;
         transfer_load_strobe <= 1'b0;
         t_load <= 1'b0;
         t_count <= '0;
      end else begin
         t_load <= 1'b0;
         case (state)
            dbdac_pkg::ST_IDLE: begin
               if (go_req) begin
                  done <= 1'b0;
                  pending <= w_data[dbdac_pkg::CTRL_SEG_LO +: 3];
                  state <= dbdac_pkg::ST_HOLD;
               end
            end
            dbdac_pkg::ST_HOLD: begin
               // Strobes low again; data held past the fall
               chip_select_n <= 1'b1;
               {high_nibble_enable, middle_nibble_enable, low_nibble_enable} <= 3'h0;
               if (pending != 3'h0) begin
                  group <= width_group(width, pending);
                  pending <= pending & ~width_group(width, pending);
                  dac_data <= code; // pin order matches nibble enables
                  t_count <= dbdac_pkg::TIMER_W'(dbdac_pkg::SETUP_CYC);
                  t_load <= 1'b1;
                  state <= dbdac_pkg::ST_SETUP;
               end else if (auto_load) begin
                  t_count <= dbdac_pkg::TIMER_W'(dbdac_pkg::SETUP_CYC);
                  t_load <= 1'b1;
                  state <= dbdac_pkg::ST_LSETUP;
               end else begin
                  state <= dbdac_pkg::ST_DONE;
               end
            end
            dbdac_pkg::ST_SETUP: begin
               if (t_exp && !t_load) begin
                  chip_select_n <= 1'b0;
                  low_nibble_enable <= group[0];
                  middle_nibble_enable <= group[1];
                  high_nibble_enable <= group[2];
                  t_count <= dbdac_pkg::TIMER_W'(dbdac_pkg::STROBE_CYC);
                  t_load <= 1'b1;
                  state <= dbdac_pkg::ST_STROBE;
               end
            end
            dbdac_pkg::ST_STROBE: begin
               if (t_exp && !t_load)
                  state <= dbdac_pkg::ST_HOLD; // overlap held full width
            end
            dbdac_pkg::ST_LSETUP: begin
               if (t_exp && !t_load) begin
                  transfer_load_strobe <= 1'b1; // chip select stays off
                  t_count <= dbdac_pkg::TIMER_W'(dbdac_pkg::STROBE_CYC);
                  t_load <= 1'b1;
                  state <= dbdac_pkg::ST_LSTROBE;
               end
            end
            dbdac_pkg::ST_LSTROBE: begin
               if (t_exp && !t_load) begin
                  transfer_load_strobe <= 1'b0;
                  state <= dbdac_pkg::ST_DONE;
               end
            end
            dbdac_pkg::ST_DONE: begin
               done <= 1'b1; // code passed unchanged, meaning set by wiring
               state <= dbdac_pkg::ST_IDLE;
            end
            default: state <= dbdac_pkg::ST_IDLE;
         endcase
      end
   end
endmodule

// ---- dbdac_host_sva.sv ----
`timescale 1ns/1ps
// Pin timing and bus answer checks for the controller
module dbdac_host_sva (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Reset, active low
   input wire logic s_axi_arvalid, // Read address valid
   input wire logic s_axi_arready, // Read address ready
   input wire logic s_axi_rvalid, // Read data valid
   input wire logic [11:0] dac_data, // Data pins
   input wire logic chip_select_n, // Chip select, active low
   input wire logic low_nibble_enable, // Low enable
   input wire logic middle_nibble_enable, // Middle enable
   input wire logic high_nibble_enable, // High enable
   input wire logic transfer_load_strobe // Transfer strobe
);
   logic en_any;
   logic stb_any;
   logic [7:0] act_cnt;
   logic [7:0] both_cnt;
   logic [7:0] stab_cnt;
   logic [11:0] data_q;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Any segment enable, any strobe
   assign en_any = low_nibble_enable | middle_nibble_enable | high_nibble_enable;
   assign stb_any = en_any | transfer_load_strobe;
   // Active time of strobes, common time with select, data stable time
   always_ff @(posedge aclk) begin
      act_cnt <= (!aresetn || !stb_any) ? 8'h00 : act_cnt + 8'h01;
      both_cnt <= (!aresetn || !(en_any && !chip_select_n)) ? 8'h00 : both_cnt + 8'h01;
      data_q <= dac_data;
      if (!aresetn || dac_data != data_q) begin
         stab_cnt <= 8'h00;
      end else if (stab_cnt != 8'hFF) begin
         stab_cnt <= stab_cnt + 8'h01;
      end
   end
   sequence s_seg_fall;
      $past(en_any) && !en_any;
   endsequence
   sequence s_any_fall;
      $past(stb_any) && !stb_any;
   endsequence
   property p_width;
      s_any_fall |-> act_cnt >= 8'h32;
   endproperty
   property p_common;
      s_seg_fall |-> both_cnt >= 8'h32;
   endproperty
   property p_hold;
      s_any_fall |-> $stable(dac_data);
   endproperty
   property p_setup;
      s_any_fall |-> stab_cnt >= 8'h32;
   endproperty
   property p_sel;
      en_any |-> !chip_select_n;
   endproperty
   property p_load_alone;
      transfer_load_strobe |-> !en_any && chip_select_n;
   endproperty
   property p_rd_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   property p_reset_idle;
      disable iff (1'h0) !aresetn |=> chip_select_n && !stb_any;
   endproperty
   a_width: assert property (p_width) else $error("strobe too short");
   a_common: assert property (p_common) else $error("common select too short");
   a_hold: assert property (p_hold) else $error("data moved at strobe fall");
   a_setup: assert property (p_setup) else $error("data setup too short");
   a_sel: assert property (p_sel) else $error("enable without select");
   a_load_alone: assert property (p_load_alone) else $error("load during write");
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
   a_reset_idle: assert property (p_reset_idle) else $error("pins not idle in reset");
endmodule
bind dbdac_host dbdac_host_sva dbdac_host_sva_inst (.aclk, .aresetn, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .dac_data, .chip_select_n, .low_nibble_enable,
   .middle_nibble_enable, .high_nibble_enable, .transfer_load_strobe);

// ---- dbdac_dev_model.sv ----
`timescale 1ns/1ps
// Double buffered converter input, level sensitive
module dbdac_dev_model (
   input wire logic [11:0] dac_data, // Data, [11] is bit 1
   input wire logic chip_select_n, // Chip select, active low
   input wire logic low_nibble_enable, // Bits 12..9 enable
   input wire logic middle_nibble_enable, // Bits 8..5 enable
   input wire logic high_nibble_enable, // Bits 4..1 enable
   input wire logic transfer_load_strobe, // Transfer strobe
   output logic [11:0] dac_code // Code at the conversion stage
);
   logic [3:0] seg_lo;
   logic [3:0] seg_mid;
   logic [3:0] seg_hi;
   // Input segments, pass at 1, hold at 0, only while selected
   always_latch begin
      if (!chip_select_n && low_nibble_enable) seg_lo <= dac_data[3:0];
   end
   always_latch begin
      if (!chip_select_n && middle_nibble_enable) seg_mid <= dac_data[7:4];
   end
   always_latch begin
      if (!chip_select_n && high_nibble_enable) seg_hi <= dac_data[11:8];
   end
   // Converter register, select not needed; code passed unchanged
   always_latch begin
      if (transfer_load_strobe) dac_code <= {seg_hi, seg_mid, seg_lo};
   end
endmodule

// ---- dbdac_host_test.sv ----
`timescale 1ns/1ps
// Self-checking bench for the converter input controller
module dbdac_host_test;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [3:0] s_axi_awaddr = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [3:0] s_axi_araddr = 4'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, en_q = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [11:0] dac_data, dac_code;
   logic chip_select_n, low_nibble_enable, middle_nibble_enable, high_nibble_enable;
   logic transfer_load_strobe;
   int bad_count = 0;
   int checks_done = 0;
   int groups = 0;
   dbdac_host dbdac_host_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dac_data,
      .chip_select_n, .low_nibble_enable, .middle_nibble_enable, .high_nibble_enable,
      .transfer_load_strobe);
   dbdac_dev_model dbdac_dev_model_inst (.dac_data, .chip_select_n, .low_nibble_enable,
      .middle_nibble_enable, .high_nibble_enable, .transfer_load_strobe, .dac_code);
   // 200 MHz clock
   initial forever #2.5 aclk = ~aclk;
   // Count segment write groups
   always @(posedge aclk) begin
      en_q <= low_nibble_enable | middle_nibble_enable | high_nibble_enable;
      if ((low_nibble_enable | middle_nibble_enable | high_nibble_enable) && !en_q) groups++;
   end
   task automatic test_done;
      $display("Checks %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic hang;
      bad_count++;
      test_done();
   endtask
   // Bus write, address and data offered together
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
      input logic [1:0] er = 2'h0);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid) break;
      end
      if (n == 100) hang();
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
      s_axi_bready <= 1'h0;
   endtask
   // Bus read
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid) break;
      end
      if (n == 100) hang();
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask
   // Poll status until done and not busy
   task automatic wait_done;
      logic [31:0] d;
      logic [1:0] r;
      int n;
      for (n = 0; n < 400; n++) begin
         axi_rd(dbdac_pkg::REG_STATUS, d, r);
         if (d[1:0] === 2'h2) break;
      end
      if (n == 400) hang();
   endtask
   function automatic logic [31:0] ctl(input logic [2:0] m, input logic [1:0] w, input logic l);
      return {22'h0, w, 1'h0, m, 2'h0, l, 1'h1};
   endfunction
   task automatic t_reset_regs;
      logic [31:0] d;
      logic [1:0] r;
      chk("cs_n idle", 32'h1, {31'h0, chip_select_n});
      axi_rd(dbdac_pkg::REG_CTRL, d, r);
      chk("ctrl reset", 32'h272, d);
      chk("ctrl resp", 32'h0, {30'h0, r});
      axi_rd(4'hC, d, r);
      chk("unmapped resp", 32'h2, {30'h0, r});
      axi_wr(4'hC, 32'h0, 2'h2);
   endtask
   // Full code over each data path width
   task automatic t_widths;
      for (int w = 0; w < 3; w++) begin
         axi_wr(dbdac_pkg::REG_CODE, 32'h9C3 + w);
         groups = 0;
         axi_wr(dbdac_pkg::REG_CTRL, ctl(3'h7, w[1:0], 1'h1));
         wait_done();
         chk("code", 32'h9C3 + w, {20'h0, dac_code});
         chk("groups", 3 - w, groups);
      end
   endtask
   // Middle segment only, held until transfer
   task automatic t_partial;
      axi_wr(dbdac_pkg::REG_CODE, 32'h123);
      axi_wr(dbdac_pkg::REG_CTRL, ctl(3'h7, 2'h2, 1'h1));
      wait_done();
      axi_wr(dbdac_pkg::REG_CODE, 32'hABC);
      axi_wr(dbdac_pkg::REG_CTRL, ctl(3'h2, 2'h0, 1'h0));
      wait_done();
      chk("code kept", 32'h123, {20'h0, dac_code});
      axi_wr(dbdac_pkg::REG_CTRL, ctl(3'h0, 2'h2, 1'h1));
      wait_done();
      chk("mid merged", 32'h1B3, {20'h0, dac_code});
   endtask
   // Code write during a sequence is ignored
   task automatic t_busy;
      logic [31:0] d;
      logic [1:0] r;
      axi_wr(dbdac_pkg::REG_CODE, 32'h777);
      axi_wr(dbdac_pkg::REG_CTRL, ctl(3'h7, 2'h0, 1'h1));
      axi_wr(dbdac_pkg::REG_CODE, 32'h0);
      axi_rd(dbdac_pkg::REG_STATUS, d, r);
      chk("busy", 32'h1, {31'h0, d[0]});
      wait_done();
      chk("busy code", 32'h777, {20'h0, dac_code});
      s_axi_wstrb <= 4'h1;
      axi_wr(dbdac_pkg::REG_CODE, 32'hFFF);
      s_axi_wstrb <= 4'hF;
      axi_rd(dbdac_pkg::REG_CODE, d, r);
      chk("code low byte", 32'h7FF, d);
   endtask
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      t_reset_regs();
      t_widths();
      t_partial();
      t_busy();
      test_done();
   end
endmodule
